//--- rtl/asm_pkg.sv
// Constants and types for the amplifier standby and mute sequencer
package asm_pkg;

	// Core clock
	localparam int CLK_HZ = 50_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;

	// Times in their own units
	localparam int  SOFT_MUTE_MS = 20;
	localparam real FAST_MUTE_MS = 0.1;
	localparam int  STARTUP_MS   = 10;
	localparam int  DISCH_MS     = 50;

	// Cycle counts; fast mute is a longest time, so it rounds down
	localparam int SOFT_CYC    = SOFT_MUTE_MS * CYC_PER_MS;
	localparam int FAST_CYC    = $rtoi(FAST_MUTE_MS * CYC_PER_MS);
	localparam int STARTUP_CYC = STARTUP_MS * CYC_PER_MS;
	localparam int DISCH_CYC   = DISCH_MS * CYC_PER_MS;
	localparam int CNT_W       = 22;

	// Instruction byte select codes on the link and instruction byte reset value
	localparam logic [1:0] SEL_IB1 = 2'h1;
	localparam logic [1:0] SEL_IB2 = 2'h2;
	localparam logic [1:0] SEL_IB3 = 2'h3;
	localparam logic [7:0] IB_RST  = 8'h00;

	// Field positions
	localparam int IB1_START      = 0;
	localparam int IB2_MUTE_FRONT = 0;
	localparam int IB2_MUTE_REAR  = 1;
	localparam int IB2_MUTE_FAST  = 2;
	localparam int IB2_NORMAL_POP = 3;
	localparam int IB3_WARN_LOW   = 4;
	localparam int IB3_WARN_FAULT_INDICATOR_PIN  = 5;

	// Standby pin level codes
	localparam logic [1:0] STB_OFF  = 2'h0;
	localparam logic [1:0] STB_MUTE = 2'h1;
	localparam logic [1:0] STB_NORM = 2'h2;

	// Positions in the analog flag vector
	localparam int A_BUS_ADDRESS_SELECT_PIN_GND = 0;
	localparam int A_VP_RESET  = 1;
	localparam int A_HR_LOW    = 2;
	localparam int A_VP_OK     = 3;
	localparam int A_VP_OV     = 4;
	localparam int A_TJ_122    = 5;
	localparam int A_TJ_145    = 6;
	localparam int A_TJ_OFF    = 7;

	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_WAIT_START,
		ST_RAMP,
		ST_RUN,
		ST_FMUTE,
		ST_DISCH,
		ST_LOWVP
	} asm_state_t;

endpackage

//--- rtl/asm_sequencer.sv
// Standby, mute and protection sequencer of a four-channel amplifier
module asm_sequencer #(
	parameter int SOFT_CYC    = asm_pkg::SOFT_CYC,
	parameter int FAST_CYC    = asm_pkg::FAST_CYC,
	parameter int STARTUP_CYC = asm_pkg::STARTUP_CYC,
	parameter int DISCH_CYC   = asm_pkg::DISCH_CYC
) (
	// Core clock and reset
	input  wire logic       I_CLK,
	input  wire logic       I_SRST,
	// Link side, instruction byte writes
	input  wire logic       I_LNK_CLK,
	input  wire logic       I_LNK_SRST,
	input  wire logic       I_LNK_WR,
	input  wire logic [1:0] I_LNK_SEL,
	input  wire logic [7:0] I_LNK_DATA,
	// Standby pin level comparators
	input  wire logic       I_STB_GT_2V5,
	input  wire logic       I_STB_GT_6V5,
	// Analog condition flags
	input  wire logic       I_BUS_ADDRESS_SELECT_PIN_GND,
	input  wire logic       I_VP_LT_RESET,
	input  wire logic       I_HR_LOW,
	input  wire logic       I_VP_GT_MUTE,
	input  wire logic       I_VP_GT_OV,
	input  wire logic       I_TJ_GT_122,
	input  wire logic       I_TJ_GT_145,
	input  wire logic       I_TJ_GT_OFF,
	// Mode and supply control
	output logic            O_STANDBY,
	output logic            O_BUS_EN,
	output logic            O_LEGACY,
	output logic            O_SVR_CHARGE,
	output logic            O_SVR_DISCHARGE,
	output logic            O_AMP_ON,
	output logic            O_LOW_POP,
	// Mute status
	output logic            O_FRONT_MUTED,
	output logic            O_REAR_MUTED,
	output logic            O_MUTE_BUSY,
	// Protection
	output logic            O_OUT_HIZ,
	output logic            O_GAIN_REDUCE,
	output logic            O_CH_OFF,
	output logic            O_POR_FLAG,
	output logic            O_TEMP_WARN,
	// Fault indicator, open drain
	output logic            O_FAULT_O,
	output logic            O_FAULT_OE_N
);

	localparam int W = asm_pkg::CNT_W;

	typedef struct packed {
		logic [1:0] sel;
		logic [7:0] data;
		logic       tog;
	} asm_lnk_t;

	typedef struct packed {
		logic [1:0]          stb_s1;
		logic [1:0]          stb_s2;
		logic [7:0]          ana_s1;
		logic [7:0]          ana_s2;
		logic                tog_s1;
		logic                tog_s2;
		logic                tog_s3;
		logic [1:0]          stb_prev;
		logic [1:0]          stb_code;
		logic [7:0]          ib1;
		logic [7:0]          ib2;
		logic [7:0]          ib3;
		logic                por;
		logic                hr_trip;
		asm_pkg::asm_state_t st;
		logic [W-1:0]        seq_cnt;
		logic                f_muted;
		logic                r_muted;
		logic [W-1:0]        f_cnt;
		logic [W-1:0]        r_cnt;
	} asm_core_t;

	asm_lnk_t  lnk_reg;
	asm_lnk_t  lnk_next;
	asm_core_t q_reg;
	asm_core_t q_next;

	logic legacy;
	logic temp_warn;
	logic fault_drive;

	////////////////////////////////////////////////////////////////////
	// Link domain: holds the last byte and flips a toggle per write

	always_comb
	begin
		lnk_next = lnk_reg;
		if (I_LNK_WR)
		begin
			lnk_next.sel  = I_LNK_SEL;
			lnk_next.data = I_LNK_DATA;
			lnk_next.tog  = ~lnk_reg.tog;
		end
	end

	always_ff @(posedge I_LNK_CLK)
	begin
		if (I_LNK_SRST)
			lnk_reg <= '0;
		else
			lnk_reg <= lnk_next;
	end

	////////////////////////////////////////////////////////////////////
	// Core domain

	// Mute pair step, release always soft; returns {muted, count}
	function automatic logic [W:0] pair_step(
		input logic         muted,
		input logic [W-1:0] cnt,
		input logic         want,
		input logic         fast,
		input logic         hold
	);
		logic [W-1:0] lim;
		lim = (want && fast) ? W'(FAST_CYC - 1) : W'(SOFT_CYC - 1);
		if (hold)
			pair_step = {1'b1, {W{1'b0}}};
		else if (want == muted)
			pair_step = {muted, {W{1'b0}}};
		else if (cnt >= lim)
			pair_step = {want, {W{1'b0}}};
		else
			pair_step = {muted, W'(cnt + 1'b1)};
	endfunction

	// Standby pin level code from the two comparators
	function automatic logic [1:0] stb_decode(input logic [1:0] lv);
		if (lv[1])
			stb_decode = asm_pkg::STB_NORM;
		else if (lv[0])
			stb_decode = asm_pkg::STB_MUTE;
		else
			stb_decode = asm_pkg::STB_OFF;
	endfunction

	always_comb
	begin
		logic [1:0]   cur;
		logic         wr_ev;
		logic         start_ev;
		logic         want_f;
		logic         want_r;
		logic         fast;
		logic         hold;
		logic         run;
		logic [W-1:0] su_lim;
		logic [W:0]   pf;
		logic [W:0]   pr;
		cur      = '0;
		wr_ev    = 1'b0;
		start_ev = 1'b0;
		want_f   = 1'b0;
		want_r   = 1'b0;
		fast     = 1'b0;
		hold     = 1'b0;
		run      = 1'b0;
		su_lim   = '0;
		pf       = '0;
		pr       = '0;
		q_next   = q_reg;

		q_next.stb_s1 = {I_STB_GT_6V5, I_STB_GT_2V5};
		q_next.stb_s2 = q_reg.stb_s1;
		q_next.ana_s1 = {I_TJ_GT_OFF, I_TJ_GT_145, I_TJ_GT_122,
			I_VP_GT_OV, I_VP_GT_MUTE, I_HR_LOW, I_VP_LT_RESET,
			I_BUS_ADDRESS_SELECT_PIN_GND};
		q_next.ana_s2 = q_reg.ana_s1;
		q_next.tog_s1 = lnk_reg.tog;
		q_next.tog_s2 = q_reg.tog_s1;
		q_next.tog_s3 = q_reg.tog_s2;

		// Two equal samples commit a level
		cur = stb_decode(q_reg.stb_s2);
		q_next.stb_prev = cur;
		if (cur == q_reg.stb_prev)
			q_next.stb_code = cur;

		wr_ev = q_reg.tog_s3 != q_reg.tog_s2;
		if (legacy)
			wr_ev = 1'b0;

		// Held link byte is stable for several core cycles after toggle
		if (wr_ev)
		begin
			unique case (lnk_reg.sel)
				asm_pkg::SEL_IB1: q_next.ib1 = lnk_reg.data;
				asm_pkg::SEL_IB2: q_next.ib2 = lnk_reg.data;
				asm_pkg::SEL_IB3: q_next.ib3 = lnk_reg.data;
				default: ;
			endcase
		end
		start_ev = wr_ev && lnk_reg.sel == asm_pkg::SEL_IB1
			&& lnk_reg.data[asm_pkg::IB1_START];

		// Start clears the flag; a set below wins
		if (start_ev)
			q_next.por = 1'b0;

		su_lim = W'(STARTUP_CYC - 1);
		if (!legacy && !q_reg.ib2[asm_pkg::IB2_NORMAL_POP])
			su_lim = W'(2 * STARTUP_CYC - 1);

		unique case (q_reg.st)
			// Stay down while pin is low
			asm_pkg::ST_STANDBY:
			begin
				q_next.seq_cnt = '0;
				q_next.hr_trip = 1'b0;
				if (q_reg.stb_code != asm_pkg::STB_OFF)
				begin
					if (legacy)
						q_next.st = asm_pkg::ST_RAMP;
					else
					begin
						q_next.por = 1'b1;
						q_next.ib1 = asm_pkg::IB_RST;
						q_next.ib2 = asm_pkg::IB_RST;
						q_next.ib3 = asm_pkg::IB_RST;
						q_next.st  = asm_pkg::ST_WAIT_START;
					end
				end
			end
			asm_pkg::ST_WAIT_START:
			begin
				if (q_reg.stb_code == asm_pkg::STB_OFF)
					q_next.st = asm_pkg::ST_STANDBY;
				else if (start_ev)
				begin
					q_next.st      = asm_pkg::ST_RAMP;
					q_next.seq_cnt = '0;
				end
			end
			asm_pkg::ST_RAMP:
			begin
				q_next.seq_cnt = W'(q_reg.seq_cnt + 1'b1);
				if (q_reg.seq_cnt >= su_lim)
				begin
					q_next.st      = asm_pkg::ST_RUN;
					q_next.seq_cnt = '0;
				end
			end
			asm_pkg::ST_RUN: ;
			asm_pkg::ST_FMUTE:
			begin
				q_next.seq_cnt = W'(q_reg.seq_cnt + 1'b1);
				if (q_reg.seq_cnt >= W'(FAST_CYC - 1))
				begin
					q_next.st      = asm_pkg::ST_DISCH;
					q_next.seq_cnt = '0;
				end
			end
			asm_pkg::ST_DISCH:
			begin
				q_next.seq_cnt = W'(q_reg.seq_cnt + 1'b1);
				if (q_reg.seq_cnt >= W'(DISCH_CYC - 1))
				begin
					q_next.seq_cnt = '0;
					q_next.st = q_reg.hr_trip ? asm_pkg::ST_LOWVP
						: asm_pkg::ST_STANDBY;
				end
			end
			// Blocked until supply above mute level
			asm_pkg::ST_LOWVP:
			begin
				q_next.seq_cnt = '0;
				if (q_reg.stb_code == asm_pkg::STB_OFF)
					q_next.st = asm_pkg::ST_STANDBY;
				else if (q_reg.ana_s2[asm_pkg::A_VP_OK])
				begin
					q_next.hr_trip = 1'b0;
					q_next.st = q_reg.por ? asm_pkg::ST_WAIT_START
						: asm_pkg::ST_RAMP;
				end
			end
			default: q_next.st = asm_pkg::ST_STANDBY;
		endcase

		run = q_reg.st == asm_pkg::ST_RAMP || q_reg.st == asm_pkg::ST_RUN;
		if (run)
		begin
			// Pin low from operating: fast mute first
			if (q_reg.stb_code == asm_pkg::STB_OFF)
			begin
				q_next.st      = asm_pkg::ST_FMUTE;
				q_next.seq_cnt = '0;
			end
			// Headroom loss: fast mute then discharge
			else if (q_reg.ana_s2[asm_pkg::A_HR_LOW])
			begin
				q_next.st      = asm_pkg::ST_FMUTE;
				q_next.seq_cnt = '0;
				q_next.hr_trip = 1'b1;
			end
		end

		// Supply reset overrides everything once awake
		if (q_reg.ana_s2[asm_pkg::A_VP_RESET]
			&& q_reg.st != asm_pkg::ST_STANDBY)
		begin
			q_next.seq_cnt = '0;
			if (legacy)
				q_next.st = asm_pkg::ST_LOWVP;
			else
			begin
				q_next.por = 1'b1;
				q_next.ib1 = asm_pkg::IB_RST;
				q_next.ib2 = asm_pkg::IB_RST;
				q_next.ib3 = asm_pkg::IB_RST;
				q_next.st  = asm_pkg::ST_WAIT_START;
			end
		end

		// Legacy mute target from pin level
		if (legacy)
		begin
			want_f = q_reg.stb_code == asm_pkg::STB_MUTE;
			want_r = want_f;
		end
		else
		begin
			// Separate front and rear soft mute
			fast   = q_reg.ib2[asm_pkg::IB2_MUTE_FAST];
			want_f = q_reg.ib2[asm_pkg::IB2_MUTE_FRONT] || fast;
			want_r = q_reg.ib2[asm_pkg::IB2_MUTE_REAR] || fast;
		end
		// Shut-down path forces fast mute on both pairs
		if (q_reg.st == asm_pkg::ST_FMUTE)
		begin
			want_f = 1'b1;
			want_r = 1'b1;
			fast   = 1'b1;
		end
		hold = q_reg.st != asm_pkg::ST_RUN && q_reg.st != asm_pkg::ST_FMUTE;

		// Soft pacing on release always; muting is soft unless fast, instant outside ST_RUN and ST_FMUTE
		pf = pair_step(q_reg.f_muted, q_reg.f_cnt, want_f, fast, hold);
		pr = pair_step(q_reg.r_muted, q_reg.r_cnt, want_r, fast, hold);
		q_next.f_muted = pf[W];
		q_next.f_cnt   = pf[W-1:0];
		q_next.r_muted = pr[W];
		q_next.r_cnt   = pr[W-1:0];

		if (legacy)
			q_next.por = 1'b0;
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
		begin
			q_reg         <= '0;
			q_reg.st      <= asm_pkg::ST_STANDBY;
			q_reg.f_muted <= 1'b1;
			q_reg.r_muted <= 1'b1;
		end
		else
			q_reg <= q_next;
	end

	////////////////////////////////////////////////////////////////////
	// Outputs

	assign legacy = q_reg.ana_s2[asm_pkg::A_BUS_ADDRESS_SELECT_PIN_GND];

	assign temp_warn = (!legacy && q_reg.ib3[asm_pkg::IB3_WARN_LOW])
		? q_reg.ana_s2[asm_pkg::A_TJ_122]
		: q_reg.ana_s2[asm_pkg::A_TJ_145];

	// OR of enabled sources; legacy always reports thermal
	assign fault_drive = (q_reg.por && !legacy)
		|| (temp_warn && (legacy || q_reg.ib3[asm_pkg::IB3_WARN_FAULT_INDICATOR_PIN]))
		|| q_reg.ana_s2[asm_pkg::A_VP_OV];

	assign O_STANDBY       = q_reg.st == asm_pkg::ST_STANDBY;
	assign O_BUS_EN        = !O_STANDBY && !legacy;
	assign O_LEGACY        = legacy;
	assign O_SVR_CHARGE    = q_reg.st == asm_pkg::ST_RAMP
		|| q_reg.st == asm_pkg::ST_RUN || q_reg.st == asm_pkg::ST_FMUTE;
	assign O_SVR_DISCHARGE = q_reg.st == asm_pkg::ST_DISCH;
	assign O_CH_OFF        = q_reg.ana_s2[asm_pkg::A_TJ_OFF];
	assign O_AMP_ON        = O_SVR_CHARGE && !O_CH_OFF;
	assign O_LOW_POP       = !legacy && !q_reg.ib2[asm_pkg::IB2_NORMAL_POP];
	assign O_FRONT_MUTED   = q_reg.f_muted;
	assign O_REAR_MUTED    = q_reg.r_muted;
	assign O_MUTE_BUSY     = q_reg.f_cnt != '0 || q_reg.r_cnt != '0;
	assign O_OUT_HIZ       = q_reg.ana_s2[asm_pkg::A_VP_OV];
	assign O_GAIN_REDUCE   = temp_warn && O_AMP_ON;
	assign O_TEMP_WARN     = temp_warn;
	assign O_POR_FLAG      = q_reg.por;
	assign O_FAULT_O       = 1'b0;
	assign O_FAULT_OE_N    = !fault_drive;

	////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_SRST);

	chk_standby_quiet: assert property (
		q_reg.st == asm_pkg::ST_STANDBY |-> !O_BUS_EN && !O_AMP_ON
		&& O_FRONT_MUTED && O_REAR_MUTED)
		else $error("bus or amplifier active in standby");

	chk_wake_por: assert property (
		q_reg.st == asm_pkg::ST_STANDBY && !legacy
		&& q_reg.stb_code != asm_pkg::STB_OFF |=> O_POR_FLAG && !O_FAULT_OE_N)
		else $error("wake in bus mode without power-on flag");

	chk_start_clear: assert property (
		q_reg.st == asm_pkg::ST_WAIT_START && $past(q_reg.st)
		== asm_pkg::ST_WAIT_START ##1 q_reg.st == asm_pkg::ST_RAMP
		|-> !q_reg.por)
		else $error("ramp entered with power-on flag still set");

	chk_soft_bound: assert property (
		q_reg.f_cnt < W'(SOFT_CYC) && q_reg.r_cnt < W'(SOFT_CYC))
		else $error("mute ramp longer than soft time");

	chk_fast_bound: assert property (
		// Entry cycle may still carry a soft count; it flips at once
		q_reg.st == asm_pkg::ST_FMUTE
		&& $past(q_reg.st) == asm_pkg::ST_FMUTE
		&& !q_reg.f_muted |-> q_reg.f_cnt < W'(FAST_CYC))
		else $error("fast mute exceeded its time");

	chk_release_soft: assert property (
		$fell(q_reg.f_muted) && $past(q_reg.st) == asm_pkg::ST_RUN
		|-> $past(q_reg.f_cnt) == W'(SOFT_CYC - 1))
		else $error("mute release not a full soft ramp");

	chk_fmute_first: assert property (
		q_reg.st == asm_pkg::ST_DISCH && $past(q_reg.st)
		!= asm_pkg::ST_DISCH |-> $past(q_reg.st) == asm_pkg::ST_FMUTE)
		else $error("discharge without preceding fast mute");

	chk_muted_ramp: assert property (
		q_reg.st == asm_pkg::ST_RAMP |=> q_reg.f_muted && q_reg.r_muted)
		else $error("outputs unmuted during start-up ramp");

	chk_legacy_pin: assert property (
		legacy && $stable(legacy) |=> !O_POR_FLAG)
		else $error("power-on flag in legacy mode");

	chk_ov_hiz: assert property (
		q_reg.ana_s2[asm_pkg::A_VP_OV] |-> O_OUT_HIZ && !O_FAULT_OE_N)
		else $error("overvoltage not handled");

endmodule

//--- sim/asm_host_model.sv
// Host side model: writes instruction bytes across the link clock domain
module asm_host_model (
	// Link clock
	input  wire logic       i_lnk_clk,
	// Byte write port
	output logic            o_wr,
	output logic [1:0]      o_sel,
	output logic [7:0]      o_data
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		o_wr = 1'b0;
		o_sel = 2'h0;
		o_data = 8'h5A;
	end

	////////////////////////////////////////////////////////////////////////
	// host byte write
	// Released data is inverted so a late capture shows up as a wrong byte.
	// Two idle link cycles follow each write before the next may start.
	task automatic put(input logic [1:0] s, input logic [7:0] d);
		@(posedge i_lnk_clk);
		o_wr <= 1'b1;
		o_sel <= s;
		o_data <= d;
		@(posedge i_lnk_clk);
		o_wr <= 1'b0;
		o_sel <= 2'h0;
		o_data <= ~d;
		repeat (2) @(posedge i_lnk_clk);
	endtask
endmodule

//--- sim/amp_standby_mute_sequencer_tb_top.sv
// Self-checking bench of the amplifier standby and mute sequencer
module amp_standby_mute_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int SC = 40;
	localparam int FC = 4;
	localparam int UC = 20;
	localparam int DC = 10;

	logic       clk = 1'b0;
	logic       lclk = 1'b0;
	logic       srst = 1'b1;
	logic       lsrst = 1'b1;
	logic       s25 = 1'b0, s65 = 1'b0, adg = 1'b0, vpr = 1'b0, hr = 1'b0;
	logic       vpm = 1'b1, ov = 1'b0, t1 = 1'b0, t2 = 1'b0, t3 = 1'b0;
	logic       lwr;
	logic [1:0] lsel;
	logic [7:0] ldat;
	logic       stby, busen, lgc, chg, dis, amp, lowp, fm, rm, hiz, gred;
	logic       choff, por, warn, fo, foen, busy;
	int         bad_count = 0;
	int         checks = 0;
	int         seed = 68706;
	int         n1, n2, n, r;
	int         ib2 = 0;
	int         ib3 = 0;
	logic       lg = 1'b0;

	always #10 clk = ~clk;
	always #62.5 lclk = ~lclk;

	asm_host_model host (
		.i_lnk_clk (lclk),
		.o_wr      (lwr),
		.o_sel     (lsel),
		.o_data    (ldat)
	);

	asm_sequencer #(
		.SOFT_CYC    (SC),
		.FAST_CYC    (FC),
		.STARTUP_CYC (UC),
		.DISCH_CYC   (DC)
	) uut (
		.I_CLK(clk), .I_SRST(srst), .I_LNK_CLK(lclk), .I_LNK_SRST(lsrst),
		.I_LNK_WR(lwr), .I_LNK_SEL(lsel), .I_LNK_DATA(ldat),
		.I_STB_GT_2V5(s25), .I_STB_GT_6V5(s65), .I_BUS_ADDRESS_SELECT_PIN_GND(adg),
		.I_VP_LT_RESET(vpr), .I_HR_LOW(hr), .I_VP_GT_MUTE(vpm),
		.I_VP_GT_OV(ov), .I_TJ_GT_122(t1), .I_TJ_GT_145(t2),
		.I_TJ_GT_OFF(t3), .O_STANDBY(stby), .O_BUS_EN(busen),
		.O_LEGACY(lgc), .O_SVR_CHARGE(chg), .O_SVR_DISCHARGE(dis),
		.O_AMP_ON(amp), .O_LOW_POP(lowp), .O_FRONT_MUTED(fm),
		.O_REAR_MUTED(rm), .O_MUTE_BUSY(busy), .O_OUT_HIZ(hiz),
		.O_GAIN_REDUCE(gred), .O_CH_OFF(choff), .O_POR_FLAG(por),
		.O_TEMP_WARN(warn), .O_FAULT_O(fo), .O_FAULT_OE_N(foen)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic s, input logic e);
		checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("BAD %0t seen %b expected %b", $time, s, e);
		end
	endtask

	// Sample 1 ns after the edge so the design's updates have landed
	task automatic tk(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask

	function automatic logic pick(input int k);
		case (k)
			0: pick = stby;
			1: pick = chg;
			2: pick = dis;
			3: pick = fm;
			4: pick = rm;
			default: pick = por;
		endcase
	endfunction

	task automatic wt(input int k, input logic v, input int lim, output int c);
		c = 0;
		while (pick(k) !== v && c < lim)
		begin
			tk(1);
			c++;
		end
		checks++;
		if (c >= lim)
		begin
			bad_count++;
			$display("BAD %0t wait ran out on %0d", $time, k);
			print_verdict();
		end
	endtask

	task automatic wr(input logic [1:0] s, input logic [7:0] d);
		host.put(s, d);
		if (!lg && s == asm_pkg::SEL_IB2)
			ib2 = d;
		if (!lg && s == asm_pkg::SEL_IB3)
			ib3 = d;
		tk(2);
	endtask

	// Expected protection outputs from the byte model and the flags
	task automatic prot(input logic run);
		logic w;
		tk(6);
		w = lg ? t2 : (ib3[4] ? t1 : t2);
		chk(warn, w);
		chk(foen, !((w && (lg || ib3[5])) || ov));
		chk(gred, w && run);
		chk(hiz, ov);
	endtask

	task automatic boot(input logic [7:0] b2, output int c);
		@(posedge clk) s25 <= 1'b1;
		wt(0, 1'b0, 12, c);
		chk(por, 1'b1);
		chk(foen, 1'b0);
		chk(busen, 1'b1);
		chk(chg, 1'b0);
		ib3 = 0;
		wr(asm_pkg::SEL_IB2, b2);
		chk(lowp, !b2[3]);
		r = $random(seed);
		wr(asm_pkg::SEL_IB1, {r[7:1], 1'b1});
		chk(por, 1'b0);
		chk(foen, 1'b1);
		chk(chg, 1'b1);
		chk(fm, 1'b1);
		wt(3, b2[0], 400, c);
	endtask

	task automatic down();
		@(posedge clk) s25 <= 1'b0;
		s65 <= 1'b0;
		wt(2, 1'b1, 20, n);
		chk(fm, 1'b1);
		chk(rm, 1'b1);
		wt(0, 1'b1, 40, n);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		lsrst <= 1'b0;
		tk(1);
		chk(stby, 1'b1);
		chk(busen, 1'b0);
		chk(foen, 1'b1);
		chk(fo, 1'b0);
		chk(lgc, 1'b0);
		@(posedge clk) s25 <= 1'b1;
		@(posedge clk) s25 <= 1'b0;
		tk(8);
		chk(stby, 1'b1);
		boot(8'h00, n1);
		wr(asm_pkg::SEL_IB2, 8'h01);
		chk(fm, 1'b0);
		chk(busy, 1'b1);
		wt(3, 1'b1, 60, n);
		chk(busy, 1'b0);
		chk(rm, 1'b0);
		wr(asm_pkg::SEL_IB2, 8'h02);
		chk(fm, 1'b1);
		wt(4, 1'b1, 60, n);
		wt(3, 1'b0, 60, n);
		wr(asm_pkg::SEL_IB2, 8'h04);
		chk(fm, 1'b1);
		chk(rm, 1'b1);
		wr(asm_pkg::SEL_IB2, 8'h08);
		chk(fm, 1'b1);
		wt(3, 1'b0, 60, n);
		wt(4, 1'b0, 60, n);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk) t1 <= 1'b1;
			t2 <= i[2];
			r = $random(seed);
			wr(asm_pkg::SEL_IB3, {2'b00, i[1:0], r[3:0]});
			prot(1'b1);
		end
		@(posedge clk) t3 <= 1'b1;
		tk(6);
		chk(choff, 1'b1);
		chk(amp, 1'b0);
		@(posedge clk) t1 <= 1'b0;
		t2 <= 1'b0;
		t3 <= 1'b0;
		@(posedge clk) ov <= 1'b1;
		tk(1);
		chk(hiz, 1'b0);
		prot(1'b1);
		@(posedge clk) ov <= 1'b0;
		prot(1'b1);
		@(posedge clk) hr <= 1'b1;
		vpm <= 1'b0;
		wt(2, 1'b1, 20, n);
		chk(fm, 1'b1);
		chk(rm, 1'b1);
		wt(2, 1'b0, 40, n);
		@(posedge clk) hr <= 1'b0;
		tk(20);
		chk(chg, 1'b0);
		chk(amp, 1'b0);
		@(posedge clk) vpm <= 1'b1;
		wt(1, 1'b1, 12, n);
		wt(3, 1'b0, 400, n);
		@(posedge clk) vpr <= 1'b1;
		wt(5, 1'b1, 12, n);
		chk(foen, 1'b0);
		chk(chg, 1'b0);
		@(posedge clk) vpr <= 1'b0;
		tk(8);
		chk(chg, 1'b0);
		chk(lowp, 1'b1);
		ib2 = 0;
		ib3 = 0;
		r = $random(seed);
		wr(asm_pkg::SEL_IB1, {r[7:1], 1'b1});
		chk(por, 1'b0);
		wt(3, 1'b0, 400, n);
		down();
		boot(8'h08, n2);
		chk(n1 - n2 >= UC - 3 && n1 - n2 <= UC + 3, 1'b1);
		down();
		boot(8'h0F, n);
		tk(120);
		chk(fm, 1'b1);
		chk(rm, 1'b1);
		down();
		@(posedge clk) adg <= 1'b1;
		lg = 1'b1;
		s25 <= 1'b1;
		wt(1, 1'b1, 20, n);
		chk(lgc, 1'b1);
		chk(busen, 1'b0);
		chk(foen, 1'b1);
		tk(100);
		chk(fm, 1'b1);
		@(posedge clk) s65 <= 1'b1;
		tk(SC - 8);
		chk(fm, 1'b1);
		wt(3, 1'b0, 20, n);
		chk(rm, 1'b0);
		wr(asm_pkg::SEL_IB2, 8'h04);
		chk(fm, 1'b0);
		@(posedge clk) t1 <= 1'b1;
		prot(1'b1);
		@(posedge clk) t2 <= 1'b1;
		prot(1'b1);
		@(posedge clk) t1 <= 1'b0;
		t2 <= 1'b0;
		@(posedge clk) vpr <= 1'b1;
		tk(6);
		chk(foen, 1'b1);
		chk(chg, 1'b0);
		chk(por, 1'b0);
		@(posedge clk) vpr <= 1'b0;
		wt(1, 1'b1, 20, n);
		wt(3, 1'b0, 400, n);
		down();
		print_verdict();
	end
endmodule
